/* File: common/legacy_pic_pkg.sv */
// How it works
// RULE1: Requests are taken as levels in a level-sensitive system and as rising edges in an edge-triggered one.
// RULE2: An end-of-interrupt command clears the in-service bit of the serviced level whatever the request line does.
// RULE3: In level mode a request still high at end-of-interrupt is seen again as a new request.
// RULE4: A level-sensitive system ignores any command that tries to select edge triggering.
// RULE5: An edge-triggered system ignores any command that tries to select level triggering.
// RULE6: A level-sensitive system keeps a readable interrupt-in-progress latch, cleared by a read or an explicit reset.
// RULE7: The handler clears the device, waits, sends end-of-interrupt, waits, then sets the enable flag.
// RULE8: The legacy cascade request line of the channel is routed to the redirected request input of the second controller.
// RULE9: The redirected request input yields vector 71 hex; the legacy sharing handler sits at vector 0A hex.
// RULE10: The redirected handler ends the second controller first, then chains to the legacy handler which ends the master.
// RULE11: The pair keeps the legacy command and status layout in edge-triggered operation.
// RULE12: Writes to the edge-sharing reset ports do not disturb the controllers.
// RULE13: The second controller cascades into master level two and the master names it during acknowledge.
package legacy_pic_pkg;

  // --------------------------------------------------------------------------
  // Vectors and levels
  // --------------------------------------------------------------------------
  localparam logic [7:0] MASTER_VEC_BASE  = 8'h08;
  localparam logic [7:0] SLAVE_VEC_BASE   = 8'h70;
  localparam logic [2:0] CASCADE_LEVEL    = 3'h2;  // Master input fed by the second controller
  localparam logic [2:0] REDIRECT_LEVEL   = 3'h1;  // Second controller input for the redirected request
  localparam logic [2:0] CASCADE_ID       = 3'h2;  // Slave identity shown during acknowledge
  localparam int         LEGACY_REQ_BIT   = 2;     // Channel line for the legacy cascade request

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] MASK_RST         = 8'h00;
  localparam logic [7:0] ISR_RST          = 8'h00;
  localparam logic [7:0] IRR_RST          = 8'h00;
  localparam logic       LATCH_RST        = 1'b0;

  // --------------------------------------------------------------------------
  // Command port
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_EOI         = 3'b000,  // Non-specific end of interrupt
    OP_SET_TRIGGER = 3'b001,  // Attempt to select trigger mode
    OP_LATCH_READ  = 3'b010,  // Read of the in-progress latch, clears it
    OP_LATCH_CLEAR = 3'b011,  // Explicit reset of the in-progress latch
    OP_SET_MASK    = 3'b100,  // Load the mask of one controller
    OP_SHARE_RESET = 3'b101   // Write to an edge-sharing reset port
  } cmd_op_t;

  typedef struct packed {
    logic       valid;
    logic       to_slave;
    cmd_op_t    op;
    logic       level_trig;  // Requested mode for OP_SET_TRIGGER
    logic [7:0] data;        // Mask for OP_SET_MASK
  } cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic       from_slave;
    logic [2:0] cascade_id;
  } ack_t;

  typedef struct packed {
    logic       found;
    logic [2:0] idx;
  } pick_t;

endpackage

/* File: rtl/legacy_pic_pair.sv */
`timescale 1ns/1ps
module legacy_pic_pair (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  level_system,
  input  wire logic [15:0]           irq_in,
  input  wire legacy_pic_pkg::cmd_t  cmd,
  input  wire logic                  inta,
  output logic                       cpu_int,
  output legacy_pic_pkg::ack_t       ack,
  output logic                       level_mode,
  output logic                       in_progress,
  output logic                       mode_refused,
  output logic [7:0]                 master_isr,
  output logic [7:0]                 slave_isr
);

  // --------------------------------------------------------------------------
  // Priority helpers
  // --------------------------------------------------------------------------
  // Lowest set bit wins, as in the fixed-priority legacy scheme
  function automatic legacy_pic_pkg::pick_t lowest(input logic [7:0] v);
    legacy_pic_pkg::pick_t p;
    p = '0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        p.found = 1'b1;
        p.idx   = 3'(i);
      end
    end
    return p;
  endfunction

  // A request is eligible only above every level already in service
  function automatic legacy_pic_pkg::pick_t eligible(input logic [7:0] req, input logic [7:0] isr);
    legacy_pic_pkg::pick_t r;
    legacy_pic_pkg::pick_t s;
    r = lowest(req);
    s = lowest(isr);
    if (s.found && (!r.found || r.idx >= s.idx)) begin
      r.found = 1'b0;
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic        strap_taken_reg;
  logic        level_reg;
  logic [15:0] prev_reg;
  logic [7:0]  m_edge_reg;
  logic [7:0]  s_edge_reg;
  logic [7:0]  m_isr_reg;
  logic [7:0]  s_isr_reg;
  logic [7:0]  m_mask_reg;
  logic [7:0]  s_mask_reg;
  logic        latch_reg;
  logic        refused_reg;
  legacy_pic_pkg::ack_t ack_reg;

  // --------------------------------------------------------------------------
  // Request routing
  // --------------------------------------------------------------------------
  // Legacy cascade request is folded into the redirected slave input
  wire logic [7:0]  s_raw      = {irq_in[15:10], irq_in[9] | irq_in[legacy_pic_pkg::LEGACY_REQ_BIT], irq_in[8]}; // RULE8
  wire logic [7:0]  m_raw      = {irq_in[7:3], 1'b0, irq_in[1:0]};
  wire logic [15:0] raw_all    = {s_raw, m_raw};
  wire logic [15:0] rise_all   = raw_all & ~prev_reg;
  // Level mode follows the pins; edge mode holds a caught rising edge
  wire logic [7:0]  s_irr      = level_reg ? s_raw : s_edge_reg;                      // RULE1 RULE3
  wire logic [7:0]  m_irr_pin  = level_reg ? m_raw : m_edge_reg;                      // RULE1 RULE3
  wire legacy_pic_pkg::pick_t s_pick = eligible(s_irr & ~s_mask_reg, s_isr_reg);
  wire logic        slave_int  = s_pick.found;
  wire logic [7:0]  m_irr      = m_irr_pin | (8'(slave_int) << legacy_pic_pkg::CASCADE_LEVEL); // RULE13
  wire legacy_pic_pkg::pick_t m_pick = eligible(m_irr & ~m_mask_reg, m_isr_reg);

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  // Acknowledge only what is shown on cpu_int, so nothing is taken before the strap
  wire logic take_ack    = inta && cpu_int;
  wire logic ack_slave   = take_ack && (m_pick.idx == legacy_pic_pkg::CASCADE_LEVEL);    // RULE13
  wire logic cmd_eoi     = cmd.valid && (cmd.op == legacy_pic_pkg::OP_EOI);
  wire logic eoi_m       = cmd_eoi && !cmd.to_slave;
  wire logic eoi_s       = cmd_eoi && cmd.to_slave;
  wire logic trig_cmd    = cmd.valid && (cmd.op == legacy_pic_pkg::OP_SET_TRIGGER);
  // The mode is fixed by the system; a differing request is dropped
  wire logic trig_bad    = trig_cmd && (cmd.level_trig != level_reg);                    // RULE4 RULE5
  wire logic mask_wr     = cmd.valid && (cmd.op == legacy_pic_pkg::OP_SET_MASK);           // RULE11
  wire logic latch_clr   = cmd.valid && ((cmd.op == legacy_pic_pkg::OP_LATCH_READ) ||
                                         (cmd.op == legacy_pic_pkg::OP_LATCH_CLEAR));      // RULE6
  wire legacy_pic_pkg::pick_t m_srv = lowest(m_isr_reg);
  wire legacy_pic_pkg::pick_t s_srv = lowest(s_isr_reg);
  // Clear happens regardless of the request pin, so a held level re-enters below
  wire logic [7:0] m_isr_clr = eoi_m && m_srv.found ? (8'h01 << m_srv.idx) : 8'h00;       // RULE2
  wire logic [7:0] s_isr_clr = eoi_s && s_srv.found ? (8'h01 << s_srv.idx) : 8'h00;       // RULE2
  wire logic [7:0] m_isr_set = take_ack ? (8'h01 << m_pick.idx) : 8'h00;
  wire logic [7:0] s_isr_set = ack_slave ? (8'h01 << s_pick.idx) : 8'h00;

  // --------------------------------------------------------------------------
  // Mode capture; the strap is sampled on the first edge after release
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_taken_reg <= 1'b0;
      level_reg       <= 1'b0;
      refused_reg     <= 1'b0;
    end else begin
      if (!strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        level_reg       <= level_system; // RULE1
      end
      refused_reg <= trig_bad;           // RULE4 RULE5
    end
  end

  // --------------------------------------------------------------------------
  // Edge catchers; the acknowledged level is consumed
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg   <= 16'h0000;
      m_edge_reg <= legacy_pic_pkg::IRR_RST;
      s_edge_reg <= legacy_pic_pkg::IRR_RST;
    end else begin
      prev_reg   <= raw_all;
      // New edge wins over the consume of the same cycle
      m_edge_reg <= (m_edge_reg & ~m_isr_set) | rise_all[7:0];  // RULE1
      s_edge_reg <= (s_edge_reg & ~s_isr_set) | rise_all[15:8]; // RULE1
    end
  end

  // --------------------------------------------------------------------------
  // In-service, mask and in-progress latch
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      m_isr_reg  <= legacy_pic_pkg::ISR_RST;
      s_isr_reg  <= legacy_pic_pkg::ISR_RST;
      m_mask_reg <= legacy_pic_pkg::MASK_RST;
      s_mask_reg <= legacy_pic_pkg::MASK_RST;
      latch_reg  <= legacy_pic_pkg::LATCH_RST;
    end else begin
      m_isr_reg <= (m_isr_reg & ~m_isr_clr) | m_isr_set; // RULE2
      s_isr_reg <= (s_isr_reg & ~s_isr_clr) | s_isr_set; // RULE2
      if (mask_wr && !cmd.to_slave) begin
        m_mask_reg <= cmd.data;
      end
      if (mask_wr && cmd.to_slave) begin
        s_mask_reg <= cmd.data;
      end
      // Set beats a read that clears in the same cycle
      latch_reg <= (latch_reg && !latch_clr) || (take_ack && level_reg); // RULE6
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge answer, one cycle after inta
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= '0;
    end else begin
      ack_reg.valid      <= take_ack;
      ack_reg.from_slave <= ack_slave;
      ack_reg.cascade_id <= ack_slave ? legacy_pic_pkg::CASCADE_ID : 3'h0;               // RULE13
      ack_reg.vector     <= ack_slave ? legacy_pic_pkg::SLAVE_VEC_BASE + 8'(s_pick.idx)  // RULE9
                                      : legacy_pic_pkg::MASTER_VEC_BASE + 8'(m_pick.idx);
    end
  end

  // Outputs; share-reset writes touch no state at all
  assign cpu_int      = m_pick.found && strap_taken_reg; // RULE12
  assign ack          = ack_reg;
  assign level_mode   = level_reg;
  assign in_progress  = latch_reg;
  assign mode_refused = refused_reg;
  assign master_isr   = m_isr_reg;
  assign slave_isr    = s_isr_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_EOI_CLEARS: assert property (@(posedge core_clk) disable iff (!resetn) // RULE2
    (eoi_m && m_srv.found && !take_ack) |=> !m_isr_reg[$past(m_srv.idx)])
    else $error("End of interrupt left the master level in service");
  AST_LEVEL_REDETECT: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
    (level_reg && m_isr_reg == 8'h00 && s_isr_reg == 8'h00 && !m_mask_reg[legacy_pic_pkg::CASCADE_LEVEL] &&
     ((|(m_raw & ~m_mask_reg)) || (|(s_raw & ~s_mask_reg)))) |-> cpu_int)
    else $error("Held level request not seen again");
  AST_EDGE_ONLY: assert property (@(posedge core_clk) disable iff (!resetn) // RULE1
    (!level_reg && !rise_all[3]) |=> ($past(m_edge_reg[3]) || !m_edge_reg[3]))
    else $error("Edge request set without a rising edge");
  AST_LOCK_LEVEL: assert property (@(posedge core_clk) disable iff (!resetn) // RULE4
    (strap_taken_reg && level_reg && trig_cmd && !cmd.level_trig) |=> (level_reg && mode_refused))
    else $error("Level system left level mode");
  AST_LOCK_EDGE: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
    (strap_taken_reg && !level_reg && trig_cmd && cmd.level_trig) |=> (!level_reg && mode_refused))
    else $error("Edge system left edge mode");
  AST_LATCH_SET: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
    (take_ack && level_reg) |=> in_progress)
    else $error("In-progress latch not set on acknowledge");
  AST_ROUTE: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
    irq_in[legacy_pic_pkg::LEGACY_REQ_BIT] |-> s_raw[legacy_pic_pkg::REDIRECT_LEVEL])
    else $error("Legacy cascade request not routed");
  AST_VEC71: assert property (@(posedge core_clk) disable iff (!resetn) // RULE9
    (ack_slave && s_pick.idx == legacy_pic_pkg::REDIRECT_LEVEL) |=> (ack.valid && ack.vector == 8'h71))
    else $error("Redirected input gave the wrong vector");
  AST_CASCADE_ID: assert property (@(posedge core_clk) disable iff (!resetn) // RULE13
    (ack.valid && ack.from_slave) |-> (ack.cascade_id == 3'h2 && master_isr[2]))
    else $error("Slave acknowledge without cascade identity");
  AST_SHARE_QUIET: assert property (@(posedge core_clk) disable iff (!resetn) // RULE12
    (cmd.valid && cmd.op == legacy_pic_pkg::OP_SHARE_RESET && !inta) |=> $stable(m_isr_reg) && $stable(s_isr_reg))
    else $error("Share reset write disturbed the controllers");

endmodule // legacy_pic_pair

/* File: bench/irq_device_model.sv */
`timescale 1ns/1ps
module irq_device_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] raise,
  input  wire logic [15:0] drop,
  output logic      [15:0] irq_lines
);
  // --------------------------------------------------------------------------
  // Request lines of the interrupting devices
  // --------------------------------------------------------------------------
  // A line stays up until its handler clears the device, so a slow handler
  // leaves the level standing across end-of-interrupt, as real cards do
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_lines <= 16'h0000;
    end else begin
      irq_lines <= (irq_lines | raise) & ~drop;
    end
  end
endmodule // irq_device_model

/* File: bench/legacy_interrupt_compat_logic_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module legacy_interrupt_compat_logic_tb_top;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic                 core_clk;
  logic                 resetn;
  logic                 level_system;
  logic                 inta;
  logic [15:0]          raise;
  logic [15:0]          drop;
  logic [15:0]          irq_in;
  legacy_pic_pkg::cmd_t cmd;
  legacy_pic_pkg::ack_t ack;
  logic                 cpu_int;
  logic                 level_mode;
  logic                 in_progress;
  logic                 mode_refused;
  logic [7:0]           master_isr;
  logic [7:0]           slave_isr;
  int                   error_cnt;
  int                   cmp_count;

  irq_device_model u_dev (.core_clk(core_clk), .resetn(resetn), .raise(raise), .drop(drop), .irq_lines(irq_in));

  legacy_pic_pair u_dut (.core_clk(core_clk), .resetn(resetn), .level_system(level_system), .irq_in(irq_in),
    .cmd(cmd), .inta(inta), .cpu_int(cpu_int), .ack(ack), .level_mode(level_mode), .in_progress(in_progress),
    .mode_refused(mode_refused), .master_isr(master_isr), .slave_isr(slave_isr));

  // --------------------------------------------------------------------------
  // Clock
  // --------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------------
  // Shared tasks, all entered and left on a falling edge
  // --------------------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Strap is captured on the first edge after release, so it is set first
  task automatic do_reset(input logic lvl);
    resetn       = 1'b0;
    level_system = lvl;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic send_cmd(input logic sl, input legacy_pic_pkg::cmd_op_t op, input logic lt,
                          input logic [7:0] d = 8'h00);
    cmd = '{valid: 1'b1, to_slave: sl, op: op, level_trig: lt, data: d};
    @(posedge core_clk);
    cmd <= '0;  // Released on the sampling edge, so back-to-back commands never glitch valid
    @(negedge core_clk);
  endtask

  task automatic dev(input int i, input logic up);
    if (up) begin
      raise[i] = 1'b1;
    end else begin
      drop[i] = 1'b1;
    end
    @(posedge core_clk);
    raise <= '0;
    drop  <= '0;
    @(negedge core_clk);
  endtask

  // Bounded wait for the request; a hang ends the run as a mismatch
  task automatic take_ack(input logic [7:0] vec, input logic sl);
    int n;
    n = 0;
    while (cpu_int !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (cpu_int !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    inta = 1'b1;
    @(negedge core_clk);
    inta = 1'b0;
    `CHK(ack.valid, 1'b1)
    `CHK(ack.vector, vec)
    `CHK(ack.from_slave, sl)
    if (sl) begin
      `CHK(ack.cascade_id, 3'h2)
      `CHK(master_isr, 8'h04)
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic sc_level_lock();
    `CHK(level_mode, 1'b1)
    send_cmd(1'b0, legacy_pic_pkg::OP_SET_TRIGGER, 1'b0);
    `CHK(mode_refused, 1'b1)
    `CHK(level_mode, 1'b1)
    send_cmd(1'b1, legacy_pic_pkg::OP_SET_TRIGGER, 1'b1);
    `CHK(mode_refused, 1'b0)
  endtask

  task automatic sc_redirect();
    dev(2, 1'b1);
    take_ack(8'h71, 1'b1);
    `CHK(slave_isr, 8'h02)
    `CHK(in_progress, 1'b1)
    send_cmd(1'b0, legacy_pic_pkg::OP_SHARE_RESET, 1'b0);
    `CHK(master_isr, 8'h04)
    send_cmd(1'b0, legacy_pic_pkg::OP_LATCH_READ, 1'b0);
    `CHK(in_progress, 1'b0)
    send_cmd(1'b1, legacy_pic_pkg::OP_EOI, 1'b0);
    `CHK(slave_isr, 8'h00)
    send_cmd(1'b0, legacy_pic_pkg::OP_EOI, 1'b0);
    `CHK(master_isr, 8'h00)
    `CHK(cpu_int, 1'b1)
    // Second pass: handler clears the device before ending the master
    take_ack(8'h71, 1'b1);
    send_cmd(1'b0, legacy_pic_pkg::OP_LATCH_CLEAR, 1'b0);
    `CHK(in_progress, 1'b0)
    send_cmd(1'b1, legacy_pic_pkg::OP_EOI, 1'b0);
    dev(2, 1'b0);
    @(negedge core_clk);
    send_cmd(1'b0, legacy_pic_pkg::OP_EOI, 1'b0);
    `CHK(master_isr, 8'h00)
    `CHK(cpu_int, 1'b0)
  endtask

  // Every level except the cascade input, with the line left high over END_OF_INTERRUPT_COMMAND
  task automatic sc_edge();
    logic [7:0] v;
    `CHK(level_mode, 1'b0)
    send_cmd(1'b0, legacy_pic_pkg::OP_SET_TRIGGER, 1'b1);
    `CHK(mode_refused, 1'b1)
    `CHK(level_mode, 1'b0)
    for (int i = 0; i < 16; i++) begin
      if (i != 2) begin
        v = (i < 8) ? 8'h08 + 8'(i) : 8'h68 + 8'(i);
        dev(i, 1'b1);
        take_ack(v, i >= 8);
        `CHK(in_progress, 1'b0)
        if (i >= 8) begin
          send_cmd(1'b1, legacy_pic_pkg::OP_EOI, 1'b0);
        end
        send_cmd(1'b0, legacy_pic_pkg::OP_EOI, 1'b0);
        `CHK(master_isr, 8'h00)
        `CHK(slave_isr, 8'h00)
        `CHK(cpu_int, 1'b0)
        dev(i, 1'b0);
      end
    end
  endtask

  // Masked level stays quiet; its caught edge is served once the mask lifts
  task automatic sc_mask();
    send_cmd(1'b0, legacy_pic_pkg::OP_SET_MASK, 1'b0, 8'h08);
    dev(3, 1'b1);
    @(negedge core_clk);
    `CHK(cpu_int, 1'b0)
    send_cmd(1'b0, legacy_pic_pkg::OP_SET_MASK, 1'b0, 8'h00);
    `CHK(cpu_int, 1'b1)
    take_ack(8'h0B, 1'b0);
    send_cmd(1'b0, legacy_pic_pkg::OP_EOI, 1'b0);
    `CHK(master_isr, 8'h00)
    dev(3, 1'b0);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    resetn       = 1'b0;
    level_system = 1'b1;
    inta         = 1'b0;
    raise        = '0;
    drop         = '0;
    cmd          = '0;
    error_cnt    = 0;
    cmp_count    = 0;
    @(negedge core_clk);
    do_reset(1'b1);
    sc_level_lock();
    sc_redirect();
    do_reset(1'b0);
    sc_edge();
    sc_mask();
    finish_test();
  end
endmodule // legacy_interrupt_compat_logic_tb_top
